// [pkg/crs_pkg.sv]
package crs_pkg;

    // ****************************************************************
    // special register addresses
    // ****************************************************************
    localparam logic [7:0] ADR_STACK_TOP  = 8'h81;
    localparam logic [7:0] ADR_PTR0_LO    = 8'h82;
    localparam logic [7:0] ADR_PTR0_HI    = 8'h83;
    localparam logic [7:0] ADR_PTR1_LO    = 8'h84;
    localparam logic [7:0] ADR_PTR1_HI    = 8'h85;
    localparam logic [7:0] ADR_FLAG_WORD  = 8'hd0;
    localparam logic [7:0] ADR_MAIN_OPND  = 8'he0;
    localparam logic [7:0] ADR_MUL_HELP   = 8'hf0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] RST_INSTR_CNT = 16'h0000;
    localparam logic [7:0]  RST_MAIN_OPND = 8'h00;
    localparam logic [7:0]  RST_MUL_HELP  = 8'h00;
    localparam logic [7:0]  RST_STACK_TOP = 8'h07;
    localparam logic [15:0] RST_DATA_PTR  = 16'h0000;
    localparam logic [7:0]  RST_FLAG_WORD = 8'h00;

    // ****************************************************************
    // flag word field positions
    // ****************************************************************
    localparam int FLG_CARRY   = 7;
    localparam int FLG_AUX     = 6;
    localparam int FLG_USER    = 5;
    localparam int FLG_BANK_HI = 4;
    localparam int FLG_BANK_LO = 3;
    localparam int FLG_OVF     = 2;
    localparam int FLG_PSEL    = 1;
    localparam int FLG_PAR     = 0;

    // ****************************************************************
    // core operations presented to the register set
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_NOP   = 4'h0,
        OP_ADD   = 4'h1,
        OP_ADDC  = 4'h2,
        OP_SUBB  = 4'h3,
        OP_ANL   = 4'h4,
        OP_ORL   = 4'h5,
        OP_XRL   = 4'h6,
        OP_MUL   = 4'h7,
        OP_DIV   = 4'h8,
        OP_PUSH  = 4'h9,
        OP_POP   = 4'ha,
        OP_DPLD  = 4'hb,
        OP_DPINC = 4'hc,
        OP_JMP   = 4'hd,
        OP_STEP  = 4'he,
        OP_LDA   = 4'hf
    } crs_op_e;

endpackage

// [src/crs_alu.sv]
`timescale 1ns/1ps
module crs_alu (
    input  wire crs_pkg::crs_op_e op,
    input  wire logic [7:0]       lhs,
    input  wire logic [7:0]       help,
    input  wire logic [7:0]       opnd,
    input  wire logic             cy_in,
    output logic [7:0]            res_a,
    output logic [7:0]            res_h,
    output logic                  we_a,
    output logic                  we_h,
    output logic                  cy,
    output logic                  ac,
    output logic                  ov,
    output logic                  we_arith
);
    import crs_pkg::*;

    logic        cin;
    logic [8:0]  sum9;
    logic [8:0]  dif9;
    logic [4:0]  nsum;
    logic [4:0]  ndif;
    logic [15:0] prod;

    // carry in only for the carry-using forms
    assign cin  = (op == OP_ADDC || op == OP_SUBB) ? cy_in : 1'b0;
    assign sum9 = {1'b0, lhs} + {1'b0, opnd} + {8'h00, cin};
    assign dif9 = {1'b0, lhs} - {1'b0, opnd} - {8'h00, cin};
    assign nsum = {1'b0, lhs[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    assign ndif = {1'b0, lhs[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
    assign prod = {8'h00, lhs} * {8'h00, help};

    // result and flag selection per operation
    always_comb begin
        res_a    = lhs;
        res_h    = help;
        we_a     = 1'b0;
        we_h     = 1'b0;
        cy       = cy_in;
        ac       = 1'b0;
        ov       = 1'b0;
        we_arith = 1'b0;
        case (op)
            OP_ADD, OP_ADDC: begin
                res_a    = sum9[7:0];
                we_a     = 1'b1;
                cy       = sum9[8];
                ac       = nsum[4];
                ov       = (lhs[7] == opnd[7]) && (sum9[7] != lhs[7]);
                we_arith = 1'b1;
            end
            OP_SUBB: begin
                res_a    = dif9[7:0];
                we_a     = 1'b1;
                cy       = dif9[8];
                ac       = ndif[4];
                ov       = (lhs[7] != opnd[7]) && (dif9[7] != lhs[7]);
                we_arith = 1'b1;
            end
            OP_ANL: begin
                res_a = lhs & opnd;
                we_a  = 1'b1;
            end
            OP_ORL: begin
                res_a = lhs | opnd;
                we_a  = 1'b1;
            end
            OP_XRL: begin
                res_a = lhs ^ opnd;
                we_a  = 1'b1;
            end
            OP_MUL: begin
                res_a    = prod[7:0];
                res_h    = prod[15:8];
                we_a     = 1'b1;
                we_h     = 1'b1;
                cy       = 1'b0;
                ov       = |prod[15:8];
                we_arith = 1'b1;
            end
            OP_DIV: begin
                // divide by zero leaves both operands and raises overflow
                cy       = 1'b0;
                ov       = (help == 8'h00);
                we_arith = 1'b1;
                if (help != 8'h00) begin
                    res_a = lhs / help;
                    res_h = lhs % help;
                    we_a  = 1'b1;
                    we_h  = 1'b1;
                end
            end
            default: begin
                we_a = 1'b0;
            end
        endcase
    end

endmodule

// [src/crs_core_regs.sv]
// Summary of operation
// RULE1: 16-bit instruction counter clears to zero on reset; fetch starts at zero.
// RULE2: instruction counter has no special register address; only transfers change it (OP_STEP also increments it).
// RULE3: multiply main operand by helper; low byte to operand, high byte to helper.
// RULE4: divide writes quotient to main operand and remainder to helper.
// RULE5: helper register is freely readable and writable outside multiply and divide.
// RULE6: 8-bit stack pointer resets to 07h and increments before each push.
// RULE7: software using banks one to three moves the stack to 80h or above.
// RULE8: two 16-bit data pointers; flag word bit 1 selects the active one.
// RULE9: each data pointer is accessible as one 16-bit value or two bytes.
// RULE10: arithmetic and logic operations update the relevant flag word bits.
// RULE11: two-bit bank field maps R0..R7 to 00h, 08h, 10h or 18h upward.
// RULE12: read-only parity flag is set when the main operand has odd ones.
// RULE13: all registers update on the rising clock edge; reset applies while active.
`timescale 1ns/1ps
module crs_core_regs (
    input  wire logic             CLK,
    input  wire logic             SYS_RST,
    input  wire logic [7:0]       SFR_ADDR,
    input  wire logic             SFR_WR,
    input  wire logic             SFR_RD,
    input  wire logic [7:0]       SFR_WDATA,
    output logic [7:0]            SFR_RDATA,
    output logic                  SFR_HIT,
    input  wire crs_pkg::crs_op_e OP_CODE,
    input  wire logic [15:0]      OP_DATA,
    input  wire logic [2:0]       REG_IDX,
    output logic [7:0]            REG_ADDR,
    output logic [7:0]            STACK_ADDR,
    output logic [15:0]           INSTR_CNT,
    output logic [7:0]            MAIN_OPND,
    output logic [7:0]            MUL_HELP,
    output logic [7:0]            STACK_TOP,
    output logic [15:0]           DATA_PTR,
    output logic [7:0]            FLAG_WORD
);
    import crs_pkg::*;

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [15:0] icnt_ff;
    logic [7:0]  opnd_ff;
    logic [7:0]  help_ff;
    logic [7:0]  stk_ff;
    logic [15:0] ptr_ff [2];
    logic        cy_ff;
    logic        ac_ff;
    logic        f0_ff;
    logic [1:0]  bank_ff;
    logic        ov_ff;
    logic        psel_ff;
    logic        par_ff;
    logic [7:0]  rdata_ff;
    logic        hit_ff;
    logic [7:0]  nxt_opnd;
    logic [7:0]  nxt_help;
    logic [7:0]  alu_a;
    logic [7:0]  alu_h;
    logic        alu_we_a;
    logic        alu_we_h;
    logic        alu_cy;
    logic        alu_ac;
    logic        alu_ov;
    logic        alu_we_ar;
    logic        wr_flags;
    logic [7:0]  rd_mux;
    logic        rd_hit;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // ****************************************************************
    // arithmetic unit
    // ****************************************************************
    crs_alu u_alu (
        .op       (OP_CODE),
        .lhs      (opnd_ff),
        .help     (help_ff),
        .opnd     (OP_DATA[7:0]),
        .cy_in    (cy_ff),
        .res_a    (alu_a),
        .res_h    (alu_h),
        .we_a     (alu_we_a),
        .we_h     (alu_we_h),
        .cy       (alu_cy),
        .ac       (alu_ac),
        .ov       (alu_ov),
        .we_arith (alu_we_ar)
    );

    assign wr_flags = SFR_WR && (SFR_ADDR == ADR_FLAG_WORD);

    // ****************************************************************
    // counter and operand registers
    // ****************************************************************
    // only jump and step move it, no special register write reaches it
    always_ff @(posedge CLK or posedge SYS_RST) begin // [RULE13]
        if (SYS_RST) begin
            icnt_ff <= RST_INSTR_CNT; // [RULE1]
        end else if (OP_CODE == OP_JMP) begin
            icnt_ff <= OP_DATA; // [RULE2]
        end else if (OP_CODE == OP_STEP) begin
            icnt_ff <= icnt_ff + 16'h0001;
        end
    end

    // operation results take priority over a same-cycle register write
    always_comb begin
        nxt_opnd = opnd_ff;
        nxt_help = help_ff;
        if (alu_we_a) begin
            nxt_opnd = alu_a; // [RULE3] [RULE4]
        end else if (OP_CODE == OP_LDA) begin
            nxt_opnd = OP_DATA[7:0];
        end else if (SFR_WR && SFR_ADDR == ADR_MAIN_OPND) begin
            nxt_opnd = SFR_WDATA;
        end
        if (alu_we_h) begin
            nxt_help = alu_h; // [RULE3] [RULE4]
        end else if (SFR_WR && SFR_ADDR == ADR_MUL_HELP) begin
            nxt_help = SFR_WDATA; // [RULE5]
        end
    end

    // operand registers and parity tracking the next operand value
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            opnd_ff <= RST_MAIN_OPND;
            help_ff <= RST_MUL_HELP;
            par_ff  <= 1'b0;
        end else begin
            opnd_ff <= nxt_opnd;
            help_ff <= nxt_help;
            par_ff  <= ^nxt_opnd; // [RULE12]
        end
    end

    // ****************************************************************
    // stack and data pointers
    // ****************************************************************
    // push pre-increments, pop post-decrements
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            stk_ff <= RST_STACK_TOP; // [RULE6]
        end else if (OP_CODE == OP_PUSH) begin
            stk_ff <= stk_ff + 8'h01; // [RULE6]
        end else if (OP_CODE == OP_POP) begin
            stk_ff <= stk_ff - 8'h01;
        end else if (SFR_WR && SFR_ADDR == ADR_STACK_TOP) begin
            stk_ff <= SFR_WDATA;
        end
    end

    // memory cell touched by the current stack operation
    assign STACK_ADDR = (OP_CODE == OP_PUSH) ? stk_ff + 8'h01 : stk_ff; // [RULE6]

    // each pointer takes 16-bit operations when selected, bytes by address
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        localparam logic [7:0] ADR_LO = (i == 0) ? ADR_PTR0_LO : ADR_PTR1_LO;
        localparam logic [7:0] ADR_HI = (i == 0) ? ADR_PTR0_HI : ADR_PTR1_HI;
        always_ff @(posedge CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
                ptr_ff[i] <= RST_DATA_PTR;
            end else if (psel_ff == 1'(i) && OP_CODE == OP_DPLD) begin
                ptr_ff[i] <= OP_DATA; // [RULE8] [RULE9]
            end else if (psel_ff == 1'(i) && OP_CODE == OP_DPINC) begin
                ptr_ff[i] <= ptr_ff[i] + 16'h0001; // [RULE8]
            end else if (SFR_WR && SFR_ADDR == ADR_LO) begin
                ptr_ff[i][7:0] <= SFR_WDATA; // [RULE9]
            end else if (SFR_WR && SFR_ADDR == ADR_HI) begin
                ptr_ff[i][15:8] <= SFR_WDATA; // [RULE9]
            end
        end
    end
    assign DATA_PTR = ptr_ff[psel_ff]; // [RULE8]

    // ****************************************************************
    // flag word and read port
    // ****************************************************************
    // arithmetic flags from operations win over a same-cycle write
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cy_ff <= RST_FLAG_WORD[FLG_CARRY];
            ac_ff <= RST_FLAG_WORD[FLG_AUX];
            ov_ff <= RST_FLAG_WORD[FLG_OVF];
        end else if (alu_we_ar) begin
            cy_ff <= alu_cy; // [RULE10]
            ac_ff <= alu_ac;
            ov_ff <= alu_ov;
        end else if (wr_flags) begin
            cy_ff <= SFR_WDATA[FLG_CARRY];
            ac_ff <= SFR_WDATA[FLG_AUX];
            ov_ff <= SFR_WDATA[FLG_OVF];
        end
    end

    // software-only fields: user flag, bank and pointer select
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            f0_ff   <= RST_FLAG_WORD[FLG_USER];
            bank_ff <= RST_FLAG_WORD[FLG_BANK_HI:FLG_BANK_LO];
            psel_ff <= RST_FLAG_WORD[FLG_PSEL];
        end else if (wr_flags) begin
            f0_ff   <= SFR_WDATA[FLG_USER];
            bank_ff <= SFR_WDATA[FLG_BANK_HI:FLG_BANK_LO];
            psel_ff <= SFR_WDATA[FLG_PSEL];
        end
    end

    assign FLAG_WORD = {cy_ff, ac_ff, f0_ff, bank_ff, ov_ff, psel_ff, par_ff};

    // working register address within the selected bank
    assign REG_ADDR = {3'b000, bank_ff, REG_IDX}; // [RULE11]

    // decode of readable addresses, unmapped reads return zero
    always_comb begin
        rd_mux = 8'h00;
        rd_hit = 1'b1;
        if (SFR_ADDR == ADR_MAIN_OPND) begin
            rd_mux = opnd_ff;
        end else if (SFR_ADDR == ADR_MUL_HELP) begin
            rd_mux = help_ff;
        end else if (SFR_ADDR == ADR_STACK_TOP) begin
            rd_mux = stk_ff;
        end else if (SFR_ADDR == ADR_PTR0_LO) begin
            rd_mux = ptr_ff[0][7:0]; // [RULE9]
        end else if (SFR_ADDR == ADR_PTR0_HI) begin
            rd_mux = ptr_ff[0][15:8];
        end else if (SFR_ADDR == ADR_PTR1_LO) begin
            rd_mux = ptr_ff[1][7:0];
        end else if (SFR_ADDR == ADR_PTR1_HI) begin
            rd_mux = ptr_ff[1][15:8];
        end else if (SFR_ADDR == ADR_FLAG_WORD) begin
            rd_mux = FLAG_WORD;
        end else begin
            rd_hit = 1'b0; // [RULE2]
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_ff <= 8'h00;
            hit_ff   <= 1'b0;
        end else if (SFR_RD) begin
            rdata_ff <= rd_mux;
            hit_ff   <= rd_hit;
        end else begin
            hit_ff   <= 1'b0;
        end
    end

    assign SFR_RDATA = rdata_ff;
    assign SFR_HIT   = hit_ff;
    assign INSTR_CNT = icnt_ff;
    assign MAIN_OPND = opnd_ff;
    assign MUL_HELP  = help_ff;
    assign STACK_TOP = stk_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_push_addr;
        OP_CODE == OP_PUSH && STACK_ADDR == 8'(STACK_TOP + 8'h01);
    endsequence
    sequence s_push_land;
        STACK_TOP == $past(STACK_ADDR);
    endsequence

    a_reset_values: assert property ($past(SYS_RST) |-> // [RULE1]
        INSTR_CNT == RST_INSTR_CNT && STACK_TOP == RST_STACK_TOP)
        else $error("counter or stack not at reset value");
    a_no_map_read: assert property (SFR_RD && !rd_hit |=> // [RULE2]
        SFR_RDATA == 8'h00 && !SFR_HIT)
        else $error("unmapped read returned data");
    a_mul_split: assert property (OP_CODE == OP_MUL |=> // [RULE3]
        {MUL_HELP, MAIN_OPND} == 16'($past(MAIN_OPND)) * 16'($past(MUL_HELP)))
        else $error("multiply result misplaced");
    a_div_split: assert property (OP_CODE == OP_DIV && MUL_HELP != 8'h00 |=> // [RULE4]
        MAIN_OPND == $past(MAIN_OPND) / $past(MUL_HELP)
        && MUL_HELP == $past(MAIN_OPND) % $past(MUL_HELP))
        else $error("divide result misplaced");
    a_help_write: assert property (OP_CODE == OP_NOP && SFR_WR // [RULE5]
        && SFR_ADDR == ADR_MUL_HELP |=> MUL_HELP == $past(SFR_WDATA))
        else $error("helper write lost");
    a_push_step: assert property (s_push_addr |=> s_push_land) // [RULE6]
        else $error("push did not pre-increment");
    a_ptr_load: assert property (OP_CODE == OP_DPLD |=> // [RULE8]
        DATA_PTR == $past(OP_DATA) && ptr_ff[!psel_ff] == $past(ptr_ff[!psel_ff]))
        else $error("pointer load went to wrong pointer");
    a_div_zero: assert property (OP_CODE == OP_DIV && MUL_HELP == 8'h00 |=> // [RULE10]
        FLAG_WORD[FLG_OVF] && !FLAG_WORD[FLG_CARRY] && $stable(MAIN_OPND))
        else $error("divide by zero flags wrong");
    a_bank_addr: assert property (REG_ADDR[7:3] == {3'b000, FLAG_WORD[FLG_BANK_HI:FLG_BANK_LO]}) // [RULE11]
        else $error("working register address off bank");
    a_parity_flag: assert property (FLAG_WORD[FLG_PAR] == ^MAIN_OPND) // [RULE12]
        else $error("parity flag disagrees with operand");
endmodule

// [verif/cpu_core_register_set_tb.sv]
`timescale 1ns/1ps
module cpu_core_register_set_tb;
    import crs_pkg::*;

    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic        clk;
    logic        sys_rst;
    logic [7:0]  sfr_addr;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic        sfr_hit;
    crs_op_e     op_code;
    logic [15:0] op_data;
    logic [2:0]  reg_idx;
    logic [7:0]  reg_addr;
    logic [7:0]  stack_addr;
    logic [15:0] instr_cnt;
    logic [7:0]  main_opnd;
    logic [7:0]  mul_help;
    logic [7:0]  stack_top;
    logic [15:0] data_ptr;
    logic [7:0]  flag_word;
    int          num_errors;
    int          checks;

    crs_core_regs crs_core_regs_inst (
        .CLK        (clk),
        .SYS_RST    (sys_rst),
        .SFR_ADDR   (sfr_addr),
        .SFR_WR     (sfr_wr),
        .SFR_RD     (sfr_rd),
        .SFR_WDATA  (sfr_wdata),
        .SFR_RDATA  (sfr_rdata),
        .SFR_HIT    (sfr_hit),
        .OP_CODE    (op_code),
        .OP_DATA    (op_data),
        .REG_IDX    (reg_idx),
        .REG_ADDR   (reg_addr),
        .STACK_ADDR (stack_addr),
        .INSTR_CNT  (instr_cnt),
        .MAIN_OPND  (main_opnd),
        .MUL_HELP   (mul_help),
        .STACK_TOP  (stack_top),
        .DATA_PTR   (data_ptr),
        .FLAG_WORD  (flag_word)
    );

    // ****************************************************************
    // clock, 8 ns period
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    // compare one value and count it
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle write strobe; result visible after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        #1;
    endtask

    // one-cycle read strobe; registered data and hit land one cycle later
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
        #1;
    endtask

    // one operation for one cycle, then idle
    task automatic op(input crs_op_e c, input logic [15:0] d);
        @(posedge clk);
        op_code <= c;
        op_data <= d;
        @(posedge clk);
        op_code <= OP_NOP;
        #1;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_values;
        chk("instr_cnt", instr_cnt, 16'h0000);
        chk("main_opnd", main_opnd, 16'h0000);
        chk("stack_top", stack_top, 16'h0007);
        chk("stack_addr", stack_addr, 16'h0007);
        chk("data_ptr", data_ptr, 16'h0000);
        chk("flag_word", flag_word, 16'h0000);
    endtask

    task automatic t_helper_and_decode;
        wr(ADR_MUL_HELP, 8'h5a);
        chk("mul_help", mul_help, 16'h005a);
        rd(ADR_MUL_HELP);
        chk("help read", sfr_rdata, 16'h005a);
        chk("help hit", sfr_hit, 16'h0001);
        rd(8'h86);
        chk("unmapped read", sfr_rdata, 16'h0000);
        chk("unmapped hit", sfr_hit, 16'h0000);
        wr(8'h86, 8'h55);
        chk("counter idle", instr_cnt, 16'h0000);
    endtask

    task automatic t_flags;
        op(OP_LDA, 16'h00ff);
        op(OP_ADD, 16'h0001);
        chk("add result", main_opnd, 16'h0000);
        chk("add flags", flag_word, 16'h00c0);
        wr(ADR_MAIN_OPND, 8'h80);
        chk("opnd write", main_opnd, 16'h0080);
        op(OP_ADD, 16'h0080);
        chk("add ov flags", flag_word, 16'h0084);
        op(OP_ADDC, 16'h0010);
        chk("addc result", main_opnd, 16'h0011);
        chk("addc flags", flag_word, 16'h0000);
        op(OP_SUBB, 16'h0012);
        chk("subb result", main_opnd, 16'h00ff);
        chk("subb flags", flag_word, 16'h00c0);
        op(OP_SUBB, 16'h0001);
        chk("subb borrow in", main_opnd, 16'h00fd);
        op(OP_ANL, 16'h000f);
        chk("anl result", main_opnd, 16'h000d);
        op(OP_ORL, 16'h0030);
        chk("orl result", main_opnd, 16'h003d);
        op(OP_XRL, 16'h00ff);
        chk("xrl flags", flag_word, 16'h0001);
        rd(ADR_FLAG_WORD);
        chk("flag read", sfr_rdata, 16'h0001);
        rd(ADR_MAIN_OPND);
        chk("opnd read", sfr_rdata, 16'h00c2);
        op(OP_LDA, 16'h0007);
        chk("odd parity", flag_word[FLG_PAR], 16'h0001);
        op(OP_LDA, 16'h0003);
        wr(ADR_FLAG_WORD, 8'h01);
        chk("parity read only", flag_word, 16'h0000);
    endtask

    task automatic t_mul_div;
        op(OP_LDA, 16'h00c8);
        wr(ADR_MUL_HELP, 8'h9b);
        op(OP_MUL, 16'h0000);
        chk("mul low", main_opnd, 16'h0018);
        chk("mul high", mul_help, 16'h0079);
        chk("mul ov", flag_word[FLG_OVF], 16'h0001);
        op(OP_LDA, 16'h00fb);
        wr(ADR_MUL_HELP, 8'h0c);
        op(OP_DIV, 16'h0000);
        chk("div quot", main_opnd, 16'h0014);
        chk("div rem", mul_help, 16'h000b);
        chk("div ov", flag_word[FLG_OVF], 16'h0000);
        wr(ADR_MUL_HELP, 8'h00);
        op(OP_DIV, 16'h0000);
        chk("div0 opnd", main_opnd, 16'h0014);
        chk("div0 ov", flag_word[FLG_OVF], 16'h0001);
    endtask

    task automatic t_stack;
        @(posedge clk);
        op_code <= OP_PUSH;
        #1;
        chk("push cell", stack_addr, 16'h0008);
        @(posedge clk);
        op_code <= OP_POP;
        #1;
        chk("push sp", stack_top, 16'h0008);
        chk("pop cell", stack_addr, 16'h0008);
        @(posedge clk);
        op_code <= OP_NOP;
        #1;
        chk("pop sp", stack_top, 16'h0007);
        wr(ADR_STACK_TOP, 8'h80);
        op(OP_PUSH, 16'h0000);
        chk("moved stack", stack_top, 16'h0081);
        rd(ADR_STACK_TOP);
        chk("sp read", sfr_rdata, 16'h0081);
    endtask

    task automatic t_banks;
        for (int bk = 0; bk < 4; bk++) begin
            @(posedge clk);
            reg_idx <= 3'(7 - bk);
            wr(ADR_FLAG_WORD, 8'(bk << 3));
            chk("bank addr", reg_addr, {8'h00, 3'b000, 2'(bk), 3'(7 - bk)});
        end
    endtask

    task automatic t_pointers;
        wr(ADR_FLAG_WORD, 8'h00);
        op(OP_DPLD, 16'h1234);
        chk("ptr0 load", data_ptr, 16'h1234);
        rd(ADR_PTR0_LO);
        chk("ptr0 lo", sfr_rdata, 16'h0034);
        rd(ADR_PTR0_HI);
        chk("ptr0 hi", sfr_rdata, 16'h0012);
        wr(ADR_FLAG_WORD, 8'h02);
        chk("ptr1 sel", data_ptr, 16'h0000);
        wr(ADR_PTR1_LO, 8'hff);
        wr(ADR_PTR1_HI, 8'h0a);
        chk("ptr1 bytes", data_ptr, 16'h0aff);
        op(OP_DPINC, 16'h0000);
        chk("ptr1 inc", data_ptr, 16'h0b00);
        wr(ADR_FLAG_WORD, 8'h00);
        chk("ptr0 kept", data_ptr, 16'h1234);
    endtask

    task automatic t_counter_and_rereset;
        op(OP_JMP, 16'habcd);
        chk("jump", instr_cnt, 16'habcd);
        op(OP_STEP, 16'h0000);
        chk("step", instr_cnt, 16'habce);
        @(posedge clk);
        sys_rst <= 1'b1;
        #1;
        t_reset_values();
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // ****************************************************************
    // verdict
    // ****************************************************************
    task automatic conclude;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // bound on the whole run
    initial begin
        #200000;
        num_errors++;
        conclude();
    end

    // main sequence
    initial begin
        num_errors = 0;
        checks     = 0;
        sys_rst    = 1'b1;
        sfr_addr   = 8'h00;
        sfr_wr     = 1'b0;
        sfr_rd     = 1'b0;
        sfr_wdata  = 8'h00;
        op_code    = OP_NOP;
        op_data    = 16'h0000;
        reg_idx    = 3'h0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        t_reset_values();
        t_helper_and_decode();
        t_flags();
        t_mul_div();
        t_stack();
        t_banks();
        t_pointers();
        t_counter_and_rereset();
        conclude();
    end
endmodule
